/* File: inc/pbrg_defines.svh */
// Constants for the PCI bus request and grant block
`ifndef PBRG_DEFINES_SVH
`define PBRG_DEFINES_SVH

// ---------------------------------------------------------------
// Sizes and reset values
// ---------------------------------------------------------------
`define PBRG_NUM_MASTERS   3
`define PBRG_SYNC_STAGES   2
`define PBRG_GRANT_IDLE    3'h7
`define PBRG_LAST_RESET    2'h2

`endif

/* File: inc/pbrg_pkg.sv */
// Types for the PCI bus request and grant block
package pbrg_pkg;

    // Arbiter state
    typedef enum logic [1:0] {
        PBRG_IDLE,
        PBRG_GRANTED,
        PBRG_PARK
    } pbrg_state_t;

    // Bridge role
    typedef enum logic {
        PBRG_MODE_HOST,
        PBRG_MODE_GUEST
    } pbrg_mode_t;

endpackage

/* File: hw/pbrg_sync.sv */
// Two flip-flop synchroniser for one level
`timescale 1ns/1ps
module pbrg_sync #(
    parameter logic RESET_VAL = 1'b1
) (
    // Clock and reset
    input  wire logic i_core_clk,
    input  wire logic i_arst_n,
    // Data
    input  wire logic i_async,
    output logic      o_sync
);

    // ---------------------------------------------------------------
    // Stages
    // ---------------------------------------------------------------
    logic meta_ff;   // First stage, read only by the second
    logic sync_ff;   // Second stage, safe to use

    // Two stage capture
    always_ff @(posedge i_core_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            meta_ff <= RESET_VAL;
            sync_ff <= RESET_VAL;
        end else begin
            meta_ff <= i_async;
            sync_ff <= meta_ff;
        end
    end

    assign o_sync = sync_ff;

endmodule

/* File: hw/pbrg_arbiter.sv */
// PCI bus request and grant logic, host arbiter and guest requester
// How it works
// R1: Host mode drives three low grants per request; the code drives one, to the chosen master only
// R2: Outside masters pull their request low
// R3: Guest mode ignores pairs two and three
// R4: Guest mode requests bus on grant one
// R5: Outside arbiter grants via request one low
// R6: Bus pins sampled on bus clock rising edge
// R7: Bus clock is 20-33 or 66 MHz; the bench runs it at 6.25 MHz (160 ns period)
// R8: Bus reset is active low input
// R9: At most one grant at any time
`timescale 1ns/1ps
`include "pbrg_defines.svh"
module pbrg_arbiter #(
    parameter int NUM_MASTERS = `PBRG_NUM_MASTERS
) (
    // Core clock and reset
    input  wire logic                   i_core_clk,
    input  wire logic                   i_arst_n,
    // Bus clock and bus reset pins
    input  wire logic                   i_pci_clk,
    input  wire logic                   i_pci_bus_reset_n,
    // Mode strap, high selects guest mode
    input  wire logic                   i_guest_mode,
    // Request pins, active low
    input  wire logic                   i_bus_request_one_n,
    input  wire logic                   i_bus_request_two_n,
    input  wire logic                   i_bus_request_three_n,
    // Grant pins, active low
    output logic                        o_bus_grant_one_n,
    output logic                        o_bus_grant_two_n,
    output logic                        o_bus_grant_three_n,
    // Internal side, guest mode request and grant
    input  wire logic                   i_own_request,
    output logic                        o_own_granted,
    // Internal side, host mode status
    output logic [NUM_MASTERS-1:0]      o_granted_master
);

    // ---------------------------------------------------------------
    // Elaboration checks
    // ---------------------------------------------------------------
    if (NUM_MASTERS != 3) begin : g_bad_masters
        $error("pbrg_arbiter serves exactly three request pairs");
    end

    // ---------------------------------------------------------------
    // Synchronisers for all pins
    // ---------------------------------------------------------------
    logic       clk_s;        // Bus clock level
    logic       prst_n_s;     // Bus reset level
    logic       mode_s;       // Mode strap level
    logic [2:0] req_n_s;      // Request levels, active low
    logic [2:0] req_n_raw;    // Raw request pins

    assign req_n_raw = {i_bus_request_three_n, i_bus_request_two_n, i_bus_request_one_n};

    pbrg_sync #(.RESET_VAL(1'b0)) u_sync_clk (
        .i_core_clk (i_core_clk),
        .i_arst_n   (i_arst_n),
        .i_async    (i_pci_clk),
        .o_sync     (clk_s)
    );

    pbrg_sync #(.RESET_VAL(1'b0)) u_sync_rst (
        .i_core_clk (i_core_clk),
        .i_arst_n   (i_arst_n),
        .i_async    (i_pci_bus_reset_n),
        .o_sync     (prst_n_s)
    );

    pbrg_sync #(.RESET_VAL(1'b0)) u_sync_mode (
        .i_core_clk (i_core_clk),
        .i_arst_n   (i_arst_n),
        .i_async    (i_guest_mode),
        .o_sync     (mode_s)
    );

    // Request pin synchronisers
    for (genvar g = 0; g < 3; g++) begin : g_req_sync
        pbrg_sync #(.RESET_VAL(1'b1)) u_sync_req (
            .i_core_clk (i_core_clk),
            .i_arst_n   (i_arst_n),
            .i_async    (req_n_raw[g]),
            .o_sync     (req_n_s[g])
        );
    end

    // ---------------------------------------------------------------
    // Bus clock edge finder and mode capture
    // ---------------------------------------------------------------
    logic              clk_d_ff;     // Delayed bus clock level
    logic              nxt_clk_d;
    logic              rise;         // One cycle at each bus clock rise
    pbrg_pkg::pbrg_mode_t mode_ff;   // Mode caught during bus reset
    pbrg_pkg::pbrg_mode_t nxt_mode;

    assign rise = clk_s & ~clk_d_ff;

    // Edge finder and mode latch, mode follows the strap while bus reset holds
    always_comb begin
        nxt_clk_d = clk_s;
        nxt_mode  = mode_ff;
        if (!prst_n_s) begin
            nxt_mode = mode_s ? pbrg_pkg::PBRG_MODE_GUEST : pbrg_pkg::PBRG_MODE_HOST;
        end
    end

    always_ff @(posedge i_core_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            clk_d_ff <= 1'b0;
            mode_ff  <= pbrg_pkg::PBRG_MODE_HOST;
        end else begin
            clk_d_ff <= nxt_clk_d;
            mode_ff  <= nxt_mode;
        end
    end

    // ---------------------------------------------------------------
    // Arbiter state, updated on bus clock rises; all but the last master served cleared while bus reset holds
    // ---------------------------------------------------------------
    pbrg_pkg::pbrg_state_t state_ff;       // Arbiter state
    pbrg_pkg::pbrg_state_t nxt_state;
    logic [2:0]            gnt_ff;         // One-hot grant, active high
    logic [2:0]            nxt_gnt;
    logic [1:0]            last_ff;        // Last master served
    logic [1:0]            nxt_last;
    logic                  own_req_ff;     // Guest request onto grant one
    logic                  nxt_own_req;
    logic                  own_gnt_ff;     // Guest grant seen
    logic                  nxt_own_gnt;
    logic [2:0]            req;            // Active high requests
    logic [1:0]            pick;           // Round robin choice
    logic                  found;          // A request was found
    logic [1:0]            idx;            // Candidate master, wrapped to 0..2
    logic [2:0]            rr_sum;         // Unwrapped candidate, wide enough for 2 + 3

    assign req = ~req_n_s;

    // Round robin search starting after the last master served
    // The sum is kept three bits wide so the wrap back to the last owner is not lost
    always_comb begin
        pick   = 2'h0;
        found  = 1'b0;
        idx    = 2'h0;
        rr_sum = 3'h0;
        for (int k = 1; k <= 3; k++) begin
            rr_sum = {1'b0, last_ff} + 3'(k);
            idx    = (rr_sum >= 3'h3) ? 2'(rr_sum - 3'h3) : rr_sum[1:0];
            if (!found && req[idx]) begin
                pick  = idx;
                found = 1'b1;
            end
        end
    end

    // Next state of arbiter and guest requester
    always_comb begin
        nxt_state   = state_ff;
        nxt_gnt     = gnt_ff;
        nxt_last    = last_ff;
        nxt_own_req = own_req_ff;
        nxt_own_gnt = own_gnt_ff;
        if (!prst_n_s) begin
            // Bus reset releases every grant
            nxt_state   = pbrg_pkg::PBRG_IDLE;
            nxt_gnt     = 3'h0;
            nxt_own_req = 1'b0;
            nxt_own_gnt = 1'b0;
        end else if (rise) begin
            // Sampled on the bus clock rising edge (see R6)
            if (mode_ff == pbrg_pkg::PBRG_MODE_GUEST) begin
                nxt_state   = pbrg_pkg::PBRG_IDLE;
                nxt_gnt     = 3'h0;                // Pairs two, three unused (see R3)
                nxt_own_req = i_own_request;       // Request on grant one (see R4)
                nxt_own_gnt = req[0] & own_req_ff; // Grant on request one (see R5)
            end else begin
                nxt_own_req = 1'b0;
                nxt_own_gnt = 1'b0;
                case (state_ff)
                    pbrg_pkg::PBRG_IDLE: begin
                        if (found) begin
                            // One-hot grant to the chosen master (see R1) (see R9)
                            nxt_gnt   = 3'h1 << pick;
                            nxt_last  = pick;
                            nxt_state = pbrg_pkg::PBRG_GRANTED;
                        end
                    end
                    pbrg_pkg::PBRG_GRANTED: begin
                        // Hold while the owner keeps asking (see R2)
                        if ((req & gnt_ff) == 3'h0) begin
                            nxt_gnt   = 3'h0;
                            nxt_state = pbrg_pkg::PBRG_PARK;
                        end
                    end
                    pbrg_pkg::PBRG_PARK: begin
                        // One dead bus clock here, then idle, so owners are at least two bus clocks apart
                        nxt_state = pbrg_pkg::PBRG_IDLE;
                    end
                    default: begin
                        nxt_state = pbrg_pkg::PBRG_IDLE;
                        nxt_gnt   = 3'h0;
                    end
                endcase
            end
        end
    end

    always_ff @(posedge i_core_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            state_ff   <= pbrg_pkg::PBRG_IDLE;
            gnt_ff     <= 3'h0;
            last_ff    <= `PBRG_LAST_RESET;
            own_req_ff <= 1'b0;
            own_gnt_ff <= 1'b0;
        end else begin
            state_ff   <= nxt_state;
            gnt_ff     <= nxt_gnt;
            last_ff    <= nxt_last;
            own_req_ff <= nxt_own_req;
            own_gnt_ff <= nxt_own_gnt;
        end
    end

    // ---------------------------------------------------------------
    // Pin outputs from flip-flops, grant one through an OR of gnt_ff[0] and own_req_ff
    // ---------------------------------------------------------------
    assign o_bus_grant_one_n   = ~(gnt_ff[0] | own_req_ff);
    assign o_bus_grant_two_n   = ~gnt_ff[1];
    assign o_bus_grant_three_n = ~gnt_ff[2];
    assign o_own_granted       = own_gnt_ff;
    assign o_granted_master    = gnt_ff;

    // ---------------------------------------------------------------
    // Checks
    // ---------------------------------------------------------------
    grant_onehot_a: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
        $onehot0(gnt_ff)) // see R9
        else $error("more than one grant active");

    guest_pairs_idle_a: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
        (mode_ff == pbrg_pkg::PBRG_MODE_GUEST && $past(mode_ff) == pbrg_pkg::PBRG_MODE_GUEST
         && $past(rise)) |-> (o_bus_grant_two_n && o_bus_grant_three_n)) // see R3
        else $error("guest mode drove grant two or three");

    guest_request_a: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
        (prst_n_s && rise && mode_ff == pbrg_pkg::PBRG_MODE_GUEST && i_own_request)
        |=> !o_bus_grant_one_n) // see R4
        else $error("guest request not shown on grant one");

    guest_grant_a: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
        $rose(o_own_granted) |-> $past(req[0]) && $past(rise)) // see R5
        else $error("guest grant without request one low");

    host_grant_req_a: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
        $rose(gnt_ff[0] | gnt_ff[1] | gnt_ff[2])
        |-> ($past(req) & gnt_ff) != 3'h0) // see R1
        else $error("grant given to a master not asking");

    edge_only_a: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
        (prst_n_s && !rise) |=> $stable(gnt_ff)) // see R6
        else $error("grant changed off a bus clock edge");

    reset_clear_a: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
        !prst_n_s |=> (gnt_ff == 3'h0 && !own_req_ff)) // see R8
        else $error("grants held during bus reset");

    host_release_a: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
        (state_ff == pbrg_pkg::PBRG_PARK) |-> gnt_ff == 3'h0) // see R9
        else $error("grant held in dead cycle");

endmodule

/* File: bench/pbrg_partner.sv */
// Model of the far side of the bus: outside masters or an outside arbiter
`timescale 1ns/1ps
module pbrg_partner (
    // Bus clock
    input  wire logic       i_pci_clk,
    // Role and pacing chosen by the bench
    input  wire logic       i_guest,
    input  wire logic       i_slow,
    input  wire logic [2:0] i_want,
    // Grant pin seen from the device
    input  wire logic       i_bus_grant_one_n,
    // Request pins towards the device
    output logic            o_bus_request_one_n,
    output logic            o_bus_request_two_n,
    output logic            o_bus_request_three_n
);
    // ---------------------------------------------------------------
    // State
    // ---------------------------------------------------------------
    logic       seen_ff = 1'b1;  // Grant pin one clock ago
    logic [1:0] pat_ff  = 2'h0;  // Pattern for unused pins

    initial begin
        o_bus_request_one_n   = 1'b1;
        o_bus_request_two_n   = 1'b1;
        o_bus_request_three_n = 1'b1;
    end

    // Pins change only at bus clock rises
    always @(posedge i_pci_clk) begin
        if (i_guest) begin
            // Arbiter answers the device after one or two clocks
            seen_ff             <= i_bus_grant_one_n;
            o_bus_request_one_n <= i_slow ? seen_ff : i_bus_grant_one_n;
            // Unused pins keep changing so a stale level never hides a fault
            pat_ff                <= pat_ff + 2'h1;
            o_bus_request_two_n   <= pat_ff[0];
            o_bus_request_three_n <= ~pat_ff[0];
        end else begin
            // Each master pulls its own request low while it wants the bus
            {o_bus_request_three_n, o_bus_request_two_n, o_bus_request_one_n} <= ~i_want;
        end
    end
endmodule

/* File: bench/pci_bus_request_grant_tb_top.sv */
// Self-checking bench for the bus request and grant block
`timescale 1ns/1ps
module pci_bus_request_grant_tb_top;
    // ---------------------------------------------------------------
    // Signals
    // ---------------------------------------------------------------
    logic       i_core_clk = 1'b0;  // Core clock, 20 ns
    logic       i_arst_n   = 1'b0;  // Core reset
    logic       pci_clk    = 1'b0;  // Bus clock, 160 ns
    logic       bus_rst_n  = 1'b0;  // Bus reset pin
    logic       guest      = 1'b0;  // Mode strap
    logic       own_req    = 1'b0;  // Internal guest request
    logic       slow       = 1'b0;  // Partner pacing
    logic [2:0] want       = 3'h0;  // Masters wanting the bus
    wire logic  req1_n, req2_n, req3_n, gnt1_n, gnt2_n, gnt3_n, own_gnt;
    wire logic [2:0] gm;            // One-hot host grant
    int mismatches = 0, n_compared = 0, seed = 5, cycles = 0;

    always #10 i_core_clk = ~i_core_clk;
    // Bus clock free-running, phase unrelated to the core clock
    initial begin
        #7;
        forever #80 pci_clk = ~pci_clk;
    end

    // ---------------------------------------------------------------
    // Instances
    // ---------------------------------------------------------------
    pbrg_arbiter pbrg_arbiter_i (.i_core_clk(i_core_clk), .i_arst_n(i_arst_n),
        .i_pci_clk(pci_clk), .i_pci_bus_reset_n(bus_rst_n), .i_guest_mode(guest),
        .i_bus_request_one_n(req1_n), .i_bus_request_two_n(req2_n),
        .i_bus_request_three_n(req3_n), .o_bus_grant_one_n(gnt1_n),
        .o_bus_grant_two_n(gnt2_n), .o_bus_grant_three_n(gnt3_n),
        .i_own_request(own_req), .o_own_granted(own_gnt), .o_granted_master(gm));
    pbrg_partner pbrg_partner_i (.i_pci_clk(pci_clk), .i_guest(guest), .i_slow(slow),
        .i_want(want), .i_bus_grant_one_n(gnt1_n), .o_bus_request_one_n(req1_n),
        .o_bus_request_two_n(req2_n), .o_bus_request_three_n(req3_n));

    // ---------------------------------------------------------------
    // Helpers
    // ---------------------------------------------------------------
    // Compare and count
    task check(input logic [2:0] seen, input logic [2:0] exp, input string msg);
        n_compared++;
        if (seen !== exp) begin
            mismatches++;
            $display("CHECK FAILED at %0t: %s", $time, msg);
        end
    endtask

    // Grant pins expected for a one-hot owner
    function automatic logic [2:0] pins_for(input logic [2:0] owner);
        return ~owner;
    endfunction

    // Conditions waited on
    function automatic logic probe(input int sel);
        case (sel)
            0: return gm !== 3'h0;
            1: return gm === 3'h0;
            2: return gnt1_n === 1'b0;
            3: return own_gnt === 1'b1;
            default: return own_gnt === 1'b0 && gnt1_n === 1'b1;
        endcase
    endfunction

    // Bounded wait, sampling after each edge settles
    task wait_on(input int sel);
        for (int n = 0; n < 200 && !probe(sel); n++) begin
            @(posedge i_core_clk);
            #1;
        end
        check(probe(sel), 3'h1, "wait ran out");
    endtask

    task verdict_line(input string name);
        $display("Test %s done, mismatches so far %0d", name, mismatches);
    endtask

    task summarize;
        $display("Compared %0d, mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    // Hang guard
    always @(posedge i_core_clk) begin
        cycles++;
        if (cycles == 30000) begin
            mismatches++;
            summarize();
        end
    end

    // ---------------------------------------------------------------
    // Main sequence
    // ---------------------------------------------------------------
    initial begin
        repeat (5) @(posedge i_core_clk);
        i_arst_n <= 1'b1;
        @(posedge i_core_clk);
        #1;
        check({gnt3_n, gnt2_n, gnt1_n}, 3'h7, "grants active after reset");
        repeat (4) @(posedge i_core_clk);
        bus_rst_n <= 1'b1;
        // Each master alone, grant held while requested, then dropped
        for (int k = 0; k < 3; k++) begin
            @(posedge i_core_clk) want <= 3'h1 << k;
            wait_on(0);
            check(gm, 3'h1 << k, "wrong owner");
            check({gnt3_n, gnt2_n, gnt1_n}, pins_for(3'h1 << k), "grant pins");
            repeat (40) @(posedge i_core_clk);
            #1;
            check({gnt3_n, gnt2_n, gnt1_n}, pins_for(3'h1 << k), "grant not held");
            @(posedge i_core_clk) want <= 3'h0;
            wait_on(1);
            check({gnt3_n, gnt2_n, gnt1_n}, 3'h7, "grant not dropped");
        end
        verdict_line("single");
        // All request at once: served in turn after the last owner
        @(posedge i_core_clk) want <= 3'h7;
        for (int k = 0; k < 3; k++) begin
            wait_on(0);
            check(gm, 3'h1 << k, "turn order");
            @(posedge i_core_clk) want[k] <= 1'b0;
            wait_on(1);
        end
        // Last owner asks again alone: the search must wrap back to it
        @(posedge i_core_clk) want <= 3'h4;
        wait_on(0);
        check(gm, 3'h4, "last owner not served again");
        @(posedge i_core_clk) want <= 3'h0;
        wait_on(1);
        verdict_line("contend");
        // Random requests: never more than one owner
        for (int r = 0; r < 300; r++) begin
            @(posedge i_core_clk);
            if (r % 12 == 0)
                want <= 3'($random(seed));
            #1;
            check(3'(gm & (gm - 3'h1)), 3'h0, "two owners");
            check({gnt3_n, gnt2_n, gnt1_n}, pins_for(gm), "pins differ from owner");
        end
        @(posedge i_core_clk) want <= 3'h0;
        wait_on(1);
        verdict_line("random");
        // Guest mode, prompt and slow outside arbiter
        @(posedge i_core_clk) begin
            bus_rst_n <= 1'b0;
            guest     <= 1'b1;
        end
        repeat (5) @(posedge i_core_clk);
        bus_rst_n <= 1'b1;
        for (int s = 0; s < 2; s++) begin
            @(posedge i_core_clk) begin
                slow    <= s[0];
                own_req <= 1'b1;
            end
            wait_on(2);
            wait_on(3);
            for (int n = 0; n < 60; n++) begin
                @(posedge i_core_clk);
                #1;
                check({gnt3_n, gnt2_n}, 2'h3, "unused grants moved");
            end
            @(posedge i_core_clk) own_req <= 1'b0;
            wait_on(4);
            check({gnt3_n, gnt2_n}, 2'h3, "unused grants moved");
        end
        verdict_line("guest");
        summarize();
    end
endmodule
